// >>> rtl/fec_pkg.sv
// Package with constants and types for the flash erase command control.
// Function
// - Bulk erase: six writes; bad byte aborts
// - Exhausted erase attempts set error flag
// - Device preprograms to 00h, then erases 0FFh
// - Bulk erase ignores every command write
// - Extra sector codes within timeout restart it
// - Timeout flag zero counting, one erasing
// - Other command during timeout aborts to read
// - Sector erase accepts only reset, suspend
// - Suspend 0B0h with flash select, erase only
// - Suspend during timeout ends the timeout
// - Toggle stops 0.1 to 15us, then read
// - Suspended: only resume, reset; sector invalid
// - Reset while suspended leaves sector invalid
// - Resume 030h with flash select continues erase
// - Protected sectors silently skipped by erase
// - Primary protect flags bits 3..0, read only
// - Security bit 7, secondary protect bits 1..0
// - Reset single write, optional unlock, read mode
// - Reset ignored in bulk, aborts sector erase
// - SRAM enabled only by its select
// - Secondary beats primary; SRAM, I/O beat flash
// - Toggle flag inverts each busy flash read
// - Polling flag zero during erase
package fec_pkg;
    // Unlock and command codes with their addresses.
    localparam logic [11:0] ADDR_U1 = 12'h555;
    localparam logic [11:0] ADDR_U2 = 12'haaa;
    localparam logic [7:0] DATA_U1 = 8'haa;
    localparam logic [7:0] DATA_U2 = 8'h55;
    localparam logic [7:0] CMD_SETUP = 8'h80;
    localparam logic [7:0] CMD_BULK = 8'h10;
    localparam logic [7:0] CMD_SECT = 8'h30;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    localparam logic [7:0] CMD_SUSP = 8'hb0;
    localparam logic [7:0] CMD_RESET = 8'hf0;
    // Protection registers inside the control register space.
    localparam logic [7:0] OFF_PRIM_PROT = 8'hc0;
    localparam logic [7:0] OFF_SEC_PROT = 8'hc2;
    // Status byte and secondary protect register bit positions.
    localparam int BIT_POLL = 7;
    localparam int BIT_TOGGLE = 6;
    localparam int BIT_ERROR = 5;
    localparam int BIT_TMO = 3;
    localparam int BIT_SECURITY = 7;
    // Sector counts.
    localparam int NPRIM = 4;
    localparam int NSEC = 2;
    localparam int NSECT = NPRIM + NSEC;
    // Timing at a 40 ns clock.
    localparam int CLK_NS = 40;
    localparam int TMO_NS = 100000;
    localparam int SUSP_NS = 100;
    localparam int TMO_CYC = TMO_NS / CLK_NS;
    localparam int SUSP_CYC = (SUSP_NS + CLK_NS - 1) / CLK_NS;
    localparam int TMO_W = 12;
    localparam logic [TMO_W-1:0] TMO_LOAD = TMO_CYC[TMO_W-1:0];
    localparam logic [1:0] SUSP_LOAD = SUSP_CYC[1:0];
    // Erase attempts before the error flag is raised.
    localparam logic [3:0] MAX_ATTEMPTS = 4'h8;

    // Bus request from the microcontroller core.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] data;
    } fec_bus_t;

    // Command sequencer states, one-hot.
    typedef enum logic [10:0] {
        ST_READ  = 11'h001,
        ST_U1    = 11'h002,
        ST_U2    = 11'h004,
        ST_U3    = 11'h008,
        ST_U4    = 11'h010,
        ST_U5    = 11'h020,
        ST_ACCUM = 11'h040,
        ST_SERA  = 11'h080,
        ST_SUSPW = 11'h100,
        ST_SUSP  = 11'h200,
        ST_BULK  = 11'h400
    } fec_state_t;
endpackage : fec_pkg

// >>> rtl/fec_erase_timer.sv
// Sector accumulation timeout counter.
`timescale 1ns/10ps
module fec_erase_timer
    import fec_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Control.
    input wire logic load,
    input wire logic stop,
    // Expiry pulse.
    output logic expired
);
    logic [TMO_W-1:0] count;
    logic [TMO_W-1:0] next_count;
    logic next_expired;

    // Count down from the load value; stop wins only without a load.
    always_comb begin
        next_count = count;
        next_expired = 1'b0;
        if (load) begin
            next_count = TMO_LOAD;
        end else if (stop) begin
            next_count = '0;
        end else if (count != '0) begin
            next_count = count - 1'b1;
            next_expired = (count == TMO_W'(1));
        end
    end

    // Registers.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            count <= '0;
            expired <= 1'b0;
        end else begin
            count <= next_count;
            expired <= next_expired;
        end
    end
endmodule : fec_erase_timer

// >>> rtl/fec_ctrl.sv
// Erase command sequencer, status, protection and select priority.
`timescale 1ns/10ps
module fec_ctrl
    import fec_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Core bus request and read data.
    input wire fec_bus_t bus,
    output logic [7:0] rdata,
    // Raw selects from the address decode logic.
    input wire logic [NPRIM-1:0] primary_sector_selects,
    input wire logic [NSEC-1:0] secondary_sector_selects,
    input wire logic sram_select,
    input wire logic control_register_space,
    // Protection straps set at programming time.
    input wire logic [NPRIM-1:0] prim_prot,
    input wire logic [NSEC-1:0] sec_prot,
    input wire logic security_set,
    // Resolved selects.
    output logic [NPRIM-1:0] prim_sel,
    output logic [NSEC-1:0] sec_sel,
    output logic sram_en,
    output logic io_en,
    // Flash array engine.
    output logic array_start,
    output logic array_erase,
    output logic [NSECT-1:0] array_sectors,
    output logic array_hold,
    input wire logic array_done,
    input wire logic array_ok,
    input wire logic [7:0] array_rdata,
    // Status.
    output logic busy,
    output logic error_flag,
    output logic [NSECT-1:0] sector_invalid
);
    // Sequencer state and erase engine bookkeeping.
    fec_state_t state, next_state;
    logic [NSECT-1:0] next_sectors;
    logic [NSECT-1:0] next_invalid;
    logic [NSECT-1:0] eff_sel;
    logic [NSECT-1:0] prot_all;
    logic [3:0] attempts, next_attempts;
    logic [1:0] susp_cnt, next_susp_cnt;
    logic eng_pre, next_eng_pre;
    logic eng_wait, next_eng_wait;
    logic toggle, next_toggle;
    logic next_error, next_start, next_erase_op;
    logic [7:0] next_rdata;
    logic [7:0] status;
    logic flash_any, wr, erasing, tmr_load, tmr_stop, tmr_exp;
    logic is_u1, is_u2, is_setup, is_bulk;

    // I/O space and SRAM win over flash; secondary wins over primary.
    always_comb begin
        eff_sel[NSECT-1:NPRIM] = secondary_sector_selects
            & {NSEC{~(sram_select | control_register_space)}};
        eff_sel[NPRIM-1:0] = primary_sector_selects
            & {NPRIM{~((|secondary_sector_selects) | sram_select
            | control_register_space)}};
    end

    assign prot_all = {sec_prot, prim_prot};
    // Only a select that survives the priority rules reaches the flash.
    assign flash_any = |eff_sel;
    // Commands count only when a flash select is high.
    assign wr = bus.wr & flash_any;
    assign is_u1 = (bus.addr[11:0] == ADDR_U1) & (bus.data == DATA_U1);
    assign is_u2 = (bus.addr[11:0] == ADDR_U2) & (bus.data == DATA_U2);
    assign is_setup = (bus.addr[11:0] == ADDR_U1)
        & (bus.data == CMD_SETUP);
    assign is_bulk = (bus.addr[11:0] == ADDR_U1) & (bus.data == CMD_BULK);
    assign erasing = (state == ST_SERA) | (state == ST_BULK)
        | (state == ST_SUSPW) | (state == ST_ACCUM);

    // Status byte; unlisted bits read as zero.
    // Bit 3 stays high outside the accumulation window by design.
    always_comb begin
        status = 8'h00;
        status[BIT_POLL] = 1'b0;
        status[BIT_TOGGLE] = toggle;
        status[BIT_ERROR] = error_flag;
        status[BIT_TMO] = (state != ST_ACCUM);
    end

    // Accumulation timeout counter; kept apart so its long count can be
    // retimed without touching the sequencer.
    fec_erase_timer i_fec_erase_timer (
        .clk(clk),
        .resetn(resetn),
        .load(tmr_load),
        .stop(tmr_stop),
        .expired(tmr_exp)
    );

    // Next-state logic for sequencer, engine and read data.
    always_comb begin
        next_state = state;
        next_sectors = array_sectors;
        next_invalid = sector_invalid;
        next_attempts = attempts;
        next_susp_cnt = susp_cnt;
        next_eng_pre = eng_pre;
        next_eng_wait = eng_wait;
        next_toggle = toggle;
        next_error = error_flag;
        next_start = 1'b0;
        next_erase_op = array_erase;
        next_rdata = 8'h00;
        tmr_load = 1'b0;
        tmr_stop = 1'b0;
        case (state)
            ST_READ: begin
                // A lone reset write leaves the sequencer in read mode.
                if (wr && is_u1) begin
                    next_state = ST_U1;
                end
                if (wr && bus.data == CMD_RESET) begin
                    next_error = 1'b0;
                end
            end

            // Any write that breaks the unlock order drops back to read.
            ST_U1: begin
                if (wr) begin
                    next_state = is_u2 ? ST_U2 : ST_READ;
                end
            end

            ST_U2: begin
                // Reset after the unlock pair also lands in read mode.
                if (wr) begin
                    next_state = is_setup ? ST_U3 : ST_READ;
                    if (bus.data == CMD_RESET) begin
                        next_error = 1'b0;
                    end
                end
            end

            // Second unlock pair after the setup code.
            ST_U3: begin
                if (wr) begin
                    next_state = is_u1 ? ST_U4 : ST_READ;
                end
            end

            ST_U4: begin
                if (wr) begin
                    next_state = is_u2 ? ST_U5 : ST_READ;
                end
            end

            // Sixth write picks bulk or sector erase; protected sectors drop.
            ST_U5: begin
                if (wr) begin
                    next_eng_pre = 1'b1;
                    next_eng_wait = 1'b0;
                    next_attempts = 4'h0;
                    if (is_bulk) begin
                        next_sectors = ~prot_all;
                        next_state = ST_BULK;
                    end else if (bus.data == CMD_SECT) begin
                        next_sectors = eff_sel & ~prot_all;
                        tmr_load = 1'b1;
                        next_state = ST_ACCUM;
                    end else begin
                        next_state = ST_READ;
                    end
                end
            end

            // The resume code equals the sector code, so 30h adds a sector.
            ST_ACCUM: begin
                if (wr) begin
                    if (bus.data == CMD_SECT) begin
                        next_sectors = array_sectors
                            | (eff_sel & ~prot_all);
                        tmr_load = 1'b1;
                    end else if (bus.data == CMD_SUSP) begin
                        tmr_stop = 1'b1;
                        next_susp_cnt = SUSP_LOAD;
                        next_state = ST_SUSPW;
                    end else if (bus.data != CMD_RESUME) begin
                        tmr_stop = 1'b1;
                        next_state = ST_READ;
                    end
                end else if (tmr_exp) begin
                    next_state = ST_SERA;
                end
            end

            ST_SERA: begin
                // Everything but reset and suspend is dropped here.
                if (wr && bus.data == CMD_RESET) begin
                    next_state = ST_READ;
                end else if (wr && bus.data == CMD_SUSP) begin
                    next_susp_cnt = SUSP_LOAD;
                    next_state = ST_SUSPW;
                end
            end

            ST_SUSPW: begin
                // Toggle keeps running until the array has parked.
                if (wr && bus.data == CMD_RESET) begin
                    next_invalid = sector_invalid | array_sectors;
                    next_state = ST_READ;
                end else if (susp_cnt == 2'h1) begin
                    next_state = ST_SUSP;
                end else begin
                    next_susp_cnt = susp_cnt - 2'h1;
                end
            end

            // Reads go to the array; only resume or reset leave this state.
            ST_SUSP: begin
                if (wr && bus.data == CMD_RESUME) begin
                    next_state = ST_SERA;
                end else if (wr && bus.data == CMD_RESET) begin
                    next_invalid = sector_invalid | array_sectors;
                    next_state = ST_READ;
                end
            end

            ST_BULK: begin
                // Writes are ignored, reset included.
                next_state = ST_BULK;
            end

            // An illegal code after an upset falls back to read mode.
            default: begin
                next_state = ST_READ;
            end
        endcase

        // Erase engine: program all to 00h, then erase with retries.
        if (state == ST_SERA || state == ST_BULK) begin
            if (!eng_wait && next_state == state) begin
                next_start = 1'b1;
                next_erase_op = ~eng_pre;
                next_eng_wait = 1'b1;
            end else if (eng_wait && array_done) begin
                next_eng_wait = 1'b0;
                if (eng_pre) begin
                    next_eng_pre = 1'b0;
                end else if (array_ok) begin
                    next_invalid = sector_invalid & ~array_sectors;
                    next_state = ST_READ;
                end else if (attempts + 4'h1 == MAX_ATTEMPTS) begin
                    next_error = 1'b1;
                    next_state = ST_READ;
                end else begin
                    next_attempts = attempts + 4'h1;
                end
            end
        end
        // A pass may end while the suspend is settling; note it so the
        // resumed erase does not wait for a done that already came.
        if (state == ST_SUSPW && eng_wait && array_done) begin
            next_eng_wait = 1'b0;
            if (eng_pre) begin
                next_eng_pre = 1'b0;
            end
        end
        // An aborted sector erase forgets the pass it was waiting for.
        if (state == ST_SERA && next_state == ST_READ && wr) begin
            next_eng_wait = 1'b0;
        end

        // Reads: status while busy or failed, else array or registers.
        // Toggle only advances on flash reads, never on SRAM or I/O reads.
        if (bus.rd && flash_any) begin
            if (erasing) begin
                next_toggle = ~toggle;
                next_rdata = status;
            end else if (error_flag) begin
                next_rdata = status;
            end else begin
                next_rdata = array_rdata;
            end
        end else if (bus.rd && control_register_space) begin
            if (bus.addr[7:0] == OFF_PRIM_PROT) begin
                next_rdata[NPRIM-1:0] = prim_prot;
            end else if (bus.addr[7:0] == OFF_SEC_PROT) begin
                next_rdata[BIT_SECURITY] = security_set;
                next_rdata[NSEC-1:0] = sec_prot;
            end
        end
    end

    // Registers for the sequencer and engine.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= ST_READ;
            array_sectors <= '0;
            sector_invalid <= '0;
            attempts <= 4'h0;
            susp_cnt <= 2'h0;
            eng_pre <= 1'b0;
            eng_wait <= 1'b0;
            toggle <= 1'b0;
            error_flag <= 1'b0;
            array_start <= 1'b0;
            array_erase <= 1'b0;
            rdata <= 8'h00;
        end else begin
            state <= next_state;
            array_sectors <= next_sectors;
            sector_invalid <= next_invalid;
            attempts <= next_attempts;
            susp_cnt <= next_susp_cnt;
            eng_pre <= next_eng_pre;
            eng_wait <= next_eng_wait;
            toggle <= next_toggle;
            error_flag <= next_error;
            array_start <= next_start;
            array_erase <= next_erase_op;
            rdata <= next_rdata;
        end
    end

    // Registered selects and busy; the SRAM is gated by its select only.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            prim_sel <= '0;
            sec_sel <= '0;
            sram_en <= 1'b0;
            io_en <= 1'b0;
            array_hold <= 1'b0;
            busy <= 1'b0;
        end else begin
            prim_sel <= eff_sel[NPRIM-1:0];
            sec_sel <= eff_sel[NSECT-1:NPRIM];
            sram_en <= sram_select;
            io_en <= control_register_space;
            array_hold <= (next_state == ST_SUSP);
            busy <= (next_state == ST_ACCUM) | (next_state == ST_SERA)
                | (next_state == ST_BULK) | (next_state == ST_SUSPW);
        end
    end
endmodule : fec_ctrl

// >>> sim/fec_checker.sv
// Port assertions for the erase command sequencer.
`timescale 1ns/10ps
module fec_checker
    import fec_pkg::*;
(
    // Clock, reset and bus.
    input wire logic clk,
    input wire logic resetn,
    input wire fec_bus_t bus,
    input wire logic [7:0] rdata,
    // Selects and straps.
    input wire logic [NPRIM-1:0] primary_sector_selects,
    input wire logic [NSEC-1:0] secondary_sector_selects,
    input wire logic sram_select,
    input wire logic control_register_space,
    input wire logic [NPRIM-1:0] prim_prot,
    input wire logic [NSEC-1:0] sec_prot,
    input wire logic [NPRIM-1:0] prim_sel,
    input wire logic [NSEC-1:0] sec_sel,
    input wire logic sram_en,
    // Array engine and status.
    input wire logic array_start,
    input wire logic array_erase,
    input wire logic [NSECT-1:0] array_sectors,
    input wire logic array_hold,
    input wire logic array_done,
    input wire logic array_ok,
    input wire logic busy,
    input wire logic error_flag
);
    logic fl_sel;
    logic fl_rd;
    logic fl_wr;
    // A flash read only counts when no SRAM or register space overrides it.
    assign fl_sel = |primary_sector_selects || |secondary_sector_selects;
    assign fl_rd = bus.rd && fl_sel && !sram_select && !control_register_space;
    assign fl_wr = bus.wr && fl_sel && !sram_select && !control_register_space;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_sram_only: assert property (sram_en |-> $past(sram_select))
        else $error("sram enabled without select");
    a_sram_wins: assert property (sram_select
        |=> !(|prim_sel) && !(|sec_sel))
        else $error("flash select beat sram");
    a_boot_wins: assert property ((|secondary_sector_selects)
        && !sram_select && !control_register_space |=> prim_sel == '0)
        else $error("primary beat secondary");
    a_toggle_flips: assert property (busy && fl_rd ##1 busy && fl_rd
        |=> rdata[BIT_TOGGLE] != $past(rdata[BIT_TOGGLE]))
        else $error("toggle bit did not flip");
    a_poll_low: assert property (busy && fl_rd |=> !rdata[BIT_POLL])
        else $error("polling bit high while busy");
    a_prot_skip: assert property (array_start
        |-> (array_sectors & {sec_prot, prim_prot}) == '0)
        else $error("protected sector in pass");
    a_erase_pass: assert property (array_done && array_ok
        && !array_erase && busy |-> ##[1:4] array_start && array_erase)
        else $error("erase pass did not follow");
    a_resume_run: assert property (array_hold && fl_wr
        && bus.data == CMD_RESUME |=> !array_hold && busy)
        else $error("resume ignored");
    a_error_idle: assert property ($rose(error_flag) |-> !busy)
        else $error("error raised while busy");

    c_erase: cover property (array_start && array_erase);
    c_hold: cover property ($rose(array_hold));
    c_error: cover property ($rose(error_flag));
endmodule : fec_checker

// >>> sim/fec_array_model.sv
// Behavioural flash array engine answering the sequencer's passes.
`timescale 1ns/10ps
module fec_array_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Pass control.
    input wire logic start,
    input wire logic erase,
    input wire logic hold,
    input wire logic fail,
    // Pass result.
    output logic done,
    output logic ok,
    output logic [7:0] rdata
);
    localparam int PASS_CYC = 40;
    int cnt;
    logic erase_l;
    // Read data moves each cycle of a running, unheld pass so a stale value is not mistaken.
    assign rdata = 8'(cnt) ^ 8'hc3;
    // Each pass runs a fixed count and freezes while held.
    always_ff @(posedge clk) begin
        done <= 1'b0;
        ok <= 1'b0;
        if (!resetn) begin
            cnt <= 0;
        end else if (start) begin
            cnt <= PASS_CYC;
            erase_l <= erase;
        end else if (cnt > 0 && !hold) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
                done <= 1'b1;
                ok <= !(fail && erase_l);
            end
        end
    end
endmodule : fec_array_model

// >>> sim/tb_fec_ctrl.sv
// Self-checking testbench for the erase command sequencer.
`timescale 1ns/10ps
module tb_fec_ctrl
    import fec_pkg::*;
;
    localparam logic [3:0] PPROT = 4'h2;
    localparam logic [1:0] SPROT = 2'h1;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    fec_bus_t bus = '0;
    logic [3:0] pss = 4'h0;
    logic [1:0] bss = 2'h0;
    logic srs = 1'b0;
    logic crs = 1'b0;
    logic fail = 1'b0;
    logic [7:0] rdata, array_rdata;
    logic [3:0] prim_sel;
    logic [1:0] sec_sel;
    logic [5:0] array_sectors, sector_invalid;
    logic sram_en, array_start, array_erase, array_hold, array_done;
    logic array_ok, busy, error_flag;
    logic io_en;
    logic sec_set = 1'b1;
    int failures = 0;
    int n_tests = 0;

    // Free-running 25 MHz clock.
    always #20 clk = ~clk;

    fec_ctrl i_fec_ctrl (.clk(clk), .resetn(resetn), .bus(bus),
        .rdata(rdata), .primary_sector_selects(pss),
        .secondary_sector_selects(bss), .sram_select(srs),
        .control_register_space(crs), .prim_prot(PPROT), .sec_prot(SPROT),
        .security_set(sec_set), .prim_sel(prim_sel), .sec_sel(sec_sel),
        .sram_en(sram_en), .io_en(io_en), .array_start(array_start),
        .array_erase(array_erase), .array_sectors(array_sectors),
        .array_hold(array_hold), .array_done(array_done),
        .array_ok(array_ok), .array_rdata(array_rdata), .busy(busy),
        .error_flag(error_flag), .sector_invalid(sector_invalid));
    fec_array_model i_fec_array_model (.clk(clk), .resetn(resetn),
        .start(array_start), .erase(array_erase), .hold(array_hold),
        .fail(fail), .done(array_done), .ok(array_ok), .rdata(array_rdata));

    task wrap_up;
        if (failures == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    task chk(input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %0t exp %h got %h", $time, exp, got);
        end
    endtask : chk

    // One-cycle write strobe, launched and dropped at falling edges.
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        bus.wr = 1'b1;
        bus.addr = a;
        bus.data = d;
        @(negedge clk);
        bus.wr = 1'b0;
    endtask : wr

    // The caller leaves the address on the bus; the registered answer is
    // taken one cycle after the strobe.
    task rd2(input logic two, output logic [7:0] d0, output logic [7:0] d1);
        @(negedge clk);
        bus.rd = 1'b1;
        @(negedge clk);
        d0 = rdata;
        bus.rd = two;
        @(negedge clk);
        bus.rd = 1'b0;
        d1 = rdata;
    endtask : rd2

    task cmd6(input logic [15:0] a, input logic [7:0] last,
              input logic [7:0] bad);
        wr({4'h0, ADDR_U1}, DATA_U1);
        wr({4'h0, ADDR_U2}, DATA_U2);
        wr({4'h0, ADDR_U1}, CMD_SETUP);
        wr({4'h0, ADDR_U1}, DATA_U1);
        wr({4'h0, ADDR_U2}, DATA_U2 ^ bad);
        wr(a, last);
    endtask : cmd6

    // Waits for start, idle or hold under a fixed bound.
    task wait_for(input int w, output int n);
        n = 0;
        while (n < 4000 && !((w == 0 && array_start === 1'b1)
               || (w == 1 && busy === 1'b0)
               || (w == 2 && array_hold === 1'b1))) begin
            @(negedge clk);
            n++;
        end
        if (n == 4000) begin
            failures++;
            $display("mismatch %0t wait timed out", $time);
            wrap_up();
        end
    endtask : wait_for

    task t_regs;
        logic [7:0] d, x;
        pss = 4'h0;
        crs = 1'b1;
        wr(16'h00c0, 8'hff);
        rd2(1'b0, d, x);
        chk({4'h0, PPROT}, d);
        chk(8'h01, 8'(io_en));
        bus.addr = 16'h00c2;
        rd2(1'b0, d, x);
        chk(8'h81, d);
        sec_set = 1'b0;
        rd2(1'b0, d, x);
        chk(8'h01, d);
        crs = 1'b0;
        pss = 4'h1;
        wr(16'h0000, CMD_RESET);
        srs = 1'b1;
        @(negedge clk);
        chk(8'h10, {3'h0, sram_en, prim_sel});
        srs = 1'b0;
        bss = 2'h1;
        repeat (2) @(negedge clk);
        chk(8'h10, {2'h0, sec_sel, prim_sel});
        bss = 2'h0;
    endtask : t_regs

    task t_sector;
        logic [7:0] d0, d1;
        int n;
        pss = 4'h1;
        cmd6(16'h0000, CMD_SECT, 8'h00);
        rd2(1'b0, d0, d1);
        chk(8'h00, d0 & 8'h08);
        repeat (1500) @(negedge clk);
        pss = 4'h4;
        wr(16'h0000, CMD_SECT);
        pss = 4'h2;
        wr(16'h0000, CMD_SECT);
        repeat (1500) @(negedge clk);
        pss = 4'h1;
        rd2(1'b0, d0, d1);
        chk(8'h00, d0 & 8'h08);
        wait_for(0, n);
        chk(8'h05, {2'h0, array_sectors});
        chk(8'h00, 8'(array_erase));
        rd2(1'b1, d0, d1);
        chk(8'h08, d1 & 8'h88);
        chk(8'h40, (d0 ^ d1) & 8'h40);
        wr(16'h0000, CMD_SETUP);
        chk(8'h01, 8'(busy));
        wait_for(1, n);
        chk(8'h00, 8'(error_flag));
    endtask : t_sector

    task t_abort;
        cmd6({4'h0, ADDR_U1}, CMD_BULK, 8'h03);
        chk(8'h00, 8'(busy));
        cmd6({4'h0, ADDR_U1}, 8'h11, 8'h00);
        chk(8'h00, 8'(busy));
        cmd6(16'h0000, CMD_SECT, 8'h00);
        wr(16'h0000, CMD_SETUP);
        chk(8'h00, 8'(busy));
    endtask : t_abort

    task t_suspend;
        int n;
        cmd6(16'h0000, CMD_SECT, 8'h00);
        wr(16'h0000, CMD_SUSP);
        wait_for(2, n);
        chk(8'h01, 8'(n <= 375));
        chk(8'h00, 8'(busy));
        wr(16'h0000, CMD_SETUP);
        chk(8'h01, 8'(array_hold));
        wr(16'h0000, CMD_RESUME);
        chk(8'h02, {6'h0, busy, array_hold});
        wait_for(0, n);
        wr(16'h0000, CMD_SUSP);
        wait_for(2, n);
        wr(16'h0000, CMD_RESET);
        chk(8'h01, {1'b0, array_hold, sector_invalid});
        repeat (100) @(negedge clk);
    endtask : t_suspend

    task t_bulk;
        logic [7:0] d, x;
        int n;
        fail = 1'b1;
        cmd6({4'h0, ADDR_U1}, CMD_BULK, 8'h00);
        wait_for(0, n);
        chk(8'h2d, {2'h0, array_sectors});
        wr(16'h0000, CMD_RESET);
        chk(8'h01, 8'(busy));
        wait_for(1, n);
        chk(8'h01, 8'(error_flag));
        rd2(1'b0, d, x);
        chk(8'h20, d & 8'h20);
        fail = 1'b0;
        wr({4'h0, ADDR_U1}, DATA_U1);
        wr({4'h0, ADDR_U2}, DATA_U2);
        wr(16'h0000, CMD_RESET);
        chk(8'h00, 8'(error_flag));
    endtask : t_bulk

    // Reset for two cycles, then run every scenario in turn.
    initial begin
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        t_regs();
        t_sector();
        t_abort();
        t_suspend();
        t_bulk();
        wrap_up();
    end
endmodule : tb_fec_ctrl

bind fec_ctrl fec_checker i_fec_checker (.*);
